// ==== tb/front_panel_checker.sv ====
`timescale 1ns/10ps
module front_panel_checker #(
   parameter int unsigned CYCLES_PER_MS = 4,
   parameter bit          WALL_PLATE    = 1'b0
) (
   input wire logic                     i_clk_sys,
   input wire logic                     i_rst,
   input wire logic                     i_hsel,
   input wire logic [31:0]              i_haddr,
   input wire logic [1:0]               i_htrans,
   input wire logic                     i_hwrite,
   input wire logic [2:0]               i_hsize,
   input wire logic [31:0]              i_hwdata,
   input wire logic                     i_hready,
   input wire logic [31:0]              o_hrdata,
   input wire logic                     o_hreadyout,
   input wire logic                     o_hresp,
   input wire logic                     i_btn_video_n,
   input wire front_panel_pkg::detect_t i_detect,
   input wire front_panel_pkg::led_t    o_led,
   input wire front_panel_pkg::route_t  o_route
);
   import front_panel_pkg::*;
   localparam int unsigned GAP_LEN  = 1000 * CYCLES_PER_MS;
   localparam logic [12:0] GAP_LEDS = 13'h18ff;
   logic        gap_q;
   logic        from_all_on;
   int unsigned gap_cnt;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   // length of the dark version-LED pause right after all-on; digit off phases look alike,
   // so only that first stretch is judged; a top digit of zero would stretch it, so keep it nonzero
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         gap_q       <= 1'b0;
         gap_cnt     <= 0;
         from_all_on <= 1'b0;
      end else begin
         gap_q   <= (o_led == GAP_LEDS);
         gap_cnt <= (o_led == GAP_LEDS) ? gap_cnt + 1 : 0;
         if (o_led == '1) begin
            from_all_on <= 1'b1;
         end else if (o_led != GAP_LEDS) begin
            from_all_on <= 1'b0;
         end
      end
   end

   // bus answers and route relations
   bus_okay_a: assert property (o_hreadyout && !o_hresp)
      else $error("bus slave not ready or not okay");
   unmapped_zero_a: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite &&
      (i_haddr[7:0] > 8'h10) |=> (o_hrdata == 32'h0)) else $error("unmapped read not zero");
   route_range_a: assert property ((o_route.video <= VID_DVIA) && (o_route.audio <= AUD_AN2))
      else $error("route outside the port list");
   embed_pair_a: assert property (o_route.embed && (o_route.audio < AUD_AN1) |->
      ({1'b0, o_route.video} == {1'b0, o_route.audio} + 4'h1)) else $error("digital audio on other port");
   analog_4k_a: assert property (o_route.embed && (o_route.audio >= AUD_AN1) |-> !o_route.passthrough)
      else $error("analog embedded while passing through");

   // start-up sequence shape and encryption LED
   all_on_a: assert property (!WALL_PLATE && $fell(i_rst) |-> ##[1:2] (o_led == '1) [*8])
      else $error("leds not all lit after reset");
   gap_len_a: assert property (gap_q && from_all_on && (o_led != GAP_LEDS) |-> (gap_cnt == GAP_LEN))
      else $error("version pause length wrong");
   hdcp_follow_a: assert property ($rose(o_led.hdcp) |-> (o_led.audio == 5'h1f) ||
      $past(i_detect.hdcp_on, 2) || $past(i_detect.hdcp_on, 3) || $past(i_detect.hdcp_on, 4))
      else $error("encryption led lit without encryption");
endmodule

bind front_panel_select_indicator front_panel_checker #(
   .CYCLES_PER_MS(CYCLES_PER_MS),
   .WALL_PLATE   (WALL_PLATE)
) u_front_panel_checker (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
   .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .i_btn_video_n(i_btn_video_n), .i_detect(i_detect), .o_led(o_led), .o_route(o_route)
);

// ==== tb/front_panel_partner.sv ====
`timescale 1ns/10ps
module front_panel_partner (
   input  wire logic                  i_clk_sys,
   input  wire front_panel_pkg::led_t i_led,
   input  wire logic                  i_press,
   input  wire logic                  i_clear,
   output logic                       o_btn_video_n,
   output int                         o_rises [5]
);
   import front_panel_pkg::*;
   logic [4:0] video_q;

   // contact closes while pressed; open it reads high through its pull-up
   assign o_btn_video_n = ~i_press;

   // the viewer counts flashes of each video LED
   always_ff @(posedge i_clk_sys) begin
      video_q <= i_led.video;
      for (int k = 0; k < 5; k++) begin
         if (i_clear) begin
            o_rises[k] <= 0;
         end else if (i_led.video[k] && !video_q[k]) begin
            o_rises[k] <= o_rises[k] + 1;
         end
      end
   end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   import front_panel_pkg::*;
   localparam int CPM = 4;
   localparam int WIN = 1000 * CPM;
   logic        i_clk_sys;
   logic        i_rst;
   logic        i_hsel;
   logic [31:0] i_haddr;
   logic [1:0]  i_htrans;
   logic        i_hwrite;
   logic [2:0]  i_hsize;
   logic [31:0] i_hwdata;
   logic        i_hready;
   logic [31:0] o_hrdata;
   logic        o_hreadyout;
   logic        o_hresp;
   logic        i_btn_video_n;
   logic        press;
   logic        clear;
   detect_t     i_detect;
   led_t        o_led;
   route_t      o_route;
   int          rises [5];
   int          err_total;
   int          tests_run;

   // one slave, so its ready is the bus ready
   assign i_hready = o_hreadyout;

   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end

   front_panel_select_indicator #(.CYCLES_PER_MS(CPM), .WALL_PLATE(1'b0)) u_front_panel_select_indicator (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
      .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
      .i_btn_video_n(i_btn_video_n), .i_detect(i_detect), .o_led(o_led), .o_route(o_route));
   front_panel_partner u_front_panel_partner (.i_clk_sys(i_clk_sys), .i_led(o_led), .i_press(press),
      .i_clear(clear), .o_btn_video_n(i_btn_video_n), .o_rises(rises));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one single transfer; a stuck slave is caught by the watchdog
   task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
      i_hsel   <= 1'b1;
      i_haddr  <= {24'h0, a};
      i_hwrite <= wr_en;
      i_htrans <= 2'b10;
      i_hsize  <= 3'h2;
      do begin
         @(posedge i_clk_sys);
      end while (i_hready !== 1'b1);
      i_htrans <= 2'b00;
      i_hsel   <= 1'b0;
      i_hwdata <= wd;
      do begin
         @(posedge i_clk_sys);
      end while (i_hready !== 1'b1);
      rdat = o_hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(1'b0, a, 32'h0, d);
   endtask

   // reads right after an edge see settled pre-edge values, so there is no race with the design
   task automatic watch(input int idx, output int on, output int tog);
      logic p;
      on = 0;
      tog = 0;
      p = o_led[idx];
      repeat (WIN) begin
         @(posedge i_clk_sys);
         on += int'(o_led[idx] === 1'b1);
         tog += int'(o_led[idx] !== p);
         p = o_led[idx];
      end
   endtask

   // 0 dark, 1 steady, 2 slow, 3 fast, 4 lit with short pause
   function automatic int mode_of(input int on, input int tog);
      if (on == 0) return 0;
      if (on == WIN) return 1;
      if (tog >= 5) return 3;
      if (on * 4 > WIN * 3) return 4;
      return 2;
   endfunction

   task automatic press_btn;
      press <= 1'b1;
      repeat (10) @(posedge i_clk_sys);
      press <= 1'b0;
      repeat (10) @(posedge i_clk_sys);
   endtask

   task automatic t_boot(input int d0, input int d1, input int d2);
      logic [31:0] s;
      while (!(o_led.video[2:0] === 3'b000 && o_led.audio === 5'h1f)) begin
         @(posedge i_clk_sys);
      end
      clear <= 1'b1;
      @(posedge i_clk_sys);
      clear <= 1'b0;
      do begin
         rd(8'h10, s);
      end while (s[10] !== 1'b0);
      check("top digit", rises[0], d0);
      check("second digit", rises[1], d1);
      check("third digit", rises[2], d2);
      check("video leds after start", o_led.video, 32'h0);
   endtask

   task automatic t_regs;
      logic [31:0] d;
      rd(8'h00, d);
      check("ctrl reset", d, 32'h0);
      rd(8'h0c, d);
      check("version reset", d, 32'h101);
      rd(8'h08, d);
      check("audio reset", d, 32'h3);
      wr(8'h04, 32'h7);
      rd(8'h04, d);
      check("video beyond list", d, 32'h0);
      wr(8'h20, 32'hffff_ffff);
      rd(8'h20, d);
      check("unmapped", d, 32'h0);
   endtask

   task automatic t_video;
      int lm [4] = '{0, 2, 3, 1};
      int on;
      int tog;
      i_detect <= '{5'b00010, 5'h0, 1'b0, 1'b1, LINK_FULL};
      wr(8'h04, 32'h1);
      repeat (10) @(posedge i_clk_sys);
      check("video led", o_led.video, 32'h2);
      check("crypt led", o_led.hdcp, 32'h1);
      check("video route", o_route.video, 32'h1);
      i_detect.hdcp_on <= 1'b0;
      wr(8'h04, 32'h0);
      repeat (10) @(posedge i_clk_sys);
      check("inactive video led", o_led.video, 32'h0);
      check("crypt led off", o_led.hdcp, 32'h0);
      for (int m = 0; m < 4; m++) begin
         i_detect.link_mode <= link_mode_t'(m);
         repeat (10) @(posedge i_clk_sys);
         watch(0, on, tog);
         check("link led", mode_of(on, tog), lm[m]);
      end
   endtask

   // audio source, valid mask, 4k, plain dvi out, embed, pass, led mode
   task automatic t_audio;
      int tab [6][7] = '{'{0, 1, 0, 0, 1, 0, 1}, '{1, 2, 0, 0, 0, 0, 4}, '{3, 8, 1, 0, 0, 1, 3},
                         '{4, 0, 0, 0, 0, 0, 2}, '{0, 1, 0, 1, 0, 0, 4}, '{4, 16, 0, 0, 1, 0, 1}};
      int on;
      int tog;
      i_detect <= '{5'b00010, 5'h0, 1'b0, 1'b0, LINK_NONE};
      wr(8'h04, 32'h1);
      foreach (tab[i]) begin
         i_detect.audio_valid <= 5'(tab[i][1]);
         i_detect.video_4k    <= tab[i][2][0];
         wr(8'h00, 32'(tab[i][3] * 2));
         wr(8'h08, 32'(tab[i][0]));
         repeat (10) @(posedge i_clk_sys);
         check("embed", o_route.embed, 32'(tab[i][4]));
         check("passthrough", o_route.passthrough, 32'(tab[i][5]));
         check("audio route", o_route.audio, 32'(tab[i][0]));
         watch(3 + tab[i][0], on, tog);
         check("audio led", mode_of(on, tog), tab[i][6]);
         check("other audio leds", 32'(o_led.audio & ~(5'h1 << tab[i][0])), 32'h0);
      end
   endtask

   task automatic t_button;
      logic [31:0] d;
      int on;
      int tog;
      i_detect <= '0;
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      for (int k = 1; k < 5; k++) begin
         press_btn;
         rd(8'h04, d);
         check("video step", d, 32'(k));
      end
      press_btn;
      rd(8'h00, d);
      check("auto on", d, 32'h1);
      watch(8, on, tog);
      check("video blink", 32'(tog > 0 && on > 0), 32'h1);
      watch(1, on, tog);
      check("auto blink", 32'(tog > 0 && on > 0), 32'h1);
      i_detect.video_valid <= 5'b00100;
      repeat (10) @(posedge i_clk_sys);
      rd(8'h10, d);
      check("auto pick", d[2:0], 32'h2);
      watch(1, on, tog);
      check("auto steady", mode_of(on, tog), 1);
      check("chosen video led", o_led.video, 32'h4);
      press_btn;
      rd(8'h00, d);
      check("auto off", d, 32'h0);
      rd(8'h04, d);
      check("wrap to first", d, 32'h0);
      check("auto led dark", o_led.auto_sel, 32'h0);
   endtask

   task automatic t_reboot;
      logic [31:0] d;
      i_detect <= '0;
      wr(8'h04, 32'h1);
      wr(8'h0c, 32'h204);
      wr(8'h00, 32'h4);
      t_boot(4, 0, 2);
      rd(8'h04, d);
      check("state kept", d, 32'h1);
   endtask

   initial begin
      repeat (95000) @(posedge i_clk_sys);
      err_total++;
      stop_test;
   end

   initial begin
      err_total = 0;
      tests_run = 0;
      i_rst = 1'b1;
      i_hsel = 1'b0;
      i_haddr = 32'h0;
      i_htrans = 2'b00;
      i_hwrite = 1'b0;
      i_hsize = 3'h2;
      i_hwdata = 32'h0;
      i_detect = '0;
      press = 1'b0;
      clear = 1'b0;
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_boot(1, 0, 1);
      t_regs;
      t_video;
      t_audio;
      t_button;
      t_reboot;
      stop_test;
   end
endmodule

// ==== verilog/front_panel_pkg.sv ====
package front_panel_pkg;

   // startup sequence, gray coded along the path
   typedef enum logic [2:0] {
      ST_WP_BLINK = 3'b000,
      ST_ALL_ON   = 3'b001,
      ST_GAP      = 3'b011,
      ST_DIGIT    = 3'b010,
      ST_ALL_OFF  = 3'b110,
      ST_RUN      = 3'b111
   } boot_state_t;

   // video port codes, in button order
   typedef enum logic [2:0] {
      VID_VGA  = 3'h0,
      VID_HDMI = 3'h1,
      VID_DP   = 3'h2,
      VID_DVID = 3'h3,
      VID_DVIA = 3'h4
   } video_port_t;

   // audio port codes; digital code + 1 equals its video port code
   typedef enum logic [2:0] {
      AUD_HDMI = 3'h0,
      AUD_DP   = 3'h1,
      AUD_DVID = 3'h2,
      AUD_AN1  = 3'h3,
      AUD_AN2  = 3'h4
   } audio_port_t;

   // link detector modes
   typedef enum logic [1:0] {
      LINK_NONE  = 2'h0,
      LINK_LOWPW = 2'h1,
      LINK_ETH   = 2'h2,
      LINK_FULL  = 2'h3
   } link_mode_t;

   // signal detector inputs
   typedef struct packed {
      logic [4:0] video_valid;
      logic [4:0] audio_valid;
      logic       video_4k;
      logic       hdcp_on;
      link_mode_t link_mode;
   } detect_t;

   // front panel LEDs, active high
   typedef struct packed {
      logic [4:0] video;
      logic [4:0] audio;
      logic       hdcp;
      logic       auto_sel;
      logic       twisted_pair_link_led;
   } led_t;

   // what reaches the transmitted output
   typedef struct packed {
      video_port_t video;
      audio_port_t audio;
      logic        embed;
      logic        passthrough;
   } route_t;

endpackage

// ==== verilog/front_panel_regs.svh ====
`ifndef FRONT_PANEL_REGS_SVH
`define FRONT_PANEL_REGS_SVH

// register byte offsets
`define FP_CTRL_OFS      8'h00
`define FP_VSEL_OFS      8'h04
`define FP_ASEL_OFS      8'h08
`define FP_FWVER_OFS     8'h0c
`define FP_STATUS_OFS    8'h10

// control register fields
`define FP_CTRL_AUTO     0
`define FP_CTRL_DVI      1
`define FP_CTRL_REBOOT   2

// firmware version fields, one nibble per digit, top LED first
`define FP_FW_D0_LSB     0
`define FP_FW_D1_LSB     4
`define FP_FW_D2_LSB     8

// status register fields
`define FP_ST_VID_LSB    0
`define FP_ST_AUD_LSB    4
`define FP_ST_EMBED      8
`define FP_ST_PASS       9
`define FP_ST_BUSY       10
`define FP_ST_SEARCH     11

// reset values
`define FP_CTRL_RST      32'h0000_0000
`define FP_FWVER_RST     12'h101
`define FP_VSEL_RST      3'h0
`define FP_ASEL_RST      3'h3

// timing, in megahertz, microseconds and milliseconds
`define FP_CLK_MHZ       250
`define FP_TICK_US       1000
`define FP_ALL_ON_MS     1000
`define FP_GAP_MS        1000
`define FP_DIGIT_ON_MS   250
`define FP_DIGIT_OFF_MS  250
`define FP_ALL_OFF_MS    500
`define FP_SLOW_MS       500
`define FP_BLINK_MS      1000
`define FP_PAUSE_MS      900
`define FP_FAST_BIT      7

`endif

// ==== verilog/front_panel_select_indicator.sv ====
`timescale 1ns/10ps
`include "front_panel_regs.svh"
module front_panel_select_indicator #(
   parameter int unsigned CYCLES_PER_MS = `FP_TICK_US * `FP_CLK_MHZ,
   parameter bit          WALL_PLATE    = 1'b0
) (
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_rst,
   input  wire logic                     i_hsel,
   input  wire logic [31:0]              i_haddr,
   input  wire logic [1:0]               i_htrans,
   input  wire logic                     i_hwrite,
   input  wire logic [2:0]               i_hsize,
   input  wire logic [31:0]              i_hwdata,
   input  wire logic                     i_hready,
   output logic      [31:0]              o_hrdata,
   output logic                          o_hreadyout,
   output logic                          o_hresp,
   input  wire logic                     i_btn_video_n,
   input  wire front_panel_pkg::detect_t i_detect,
   output front_panel_pkg::led_t         o_led,
   output front_panel_pkg::route_t       o_route
);
   import front_panel_pkg::*;

   localparam int unsigned DETW = $bits(detect_t);

   // a tick needs two cycles at least, and the prescaler counts in 20 bits;
   // refuse anything else while the design is built, not when it runs
   if (CYCLES_PER_MS < 2 || CYCLES_PER_MS > (1 << 20)) begin : g_cpm_check
      $error("CYCLES_PER_MS out of range");
   end

   // ---------------- pin synchronisers ----------------
   logic [DETW-1:0] det_meta_reg;
   logic [DETW-1:0] det_sync_reg;
   logic [2:0]      btn_reg;      // [0] meta, [1] sync, [2] previous
   detect_t         det;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         det_meta_reg <= '0;
         det_sync_reg <= '0;
         btn_reg      <= 3'h7;
      end else begin
         det_meta_reg <= i_detect;
         det_sync_reg <= det_meta_reg;
         btn_reg      <= {btn_reg[1:0], i_btn_video_n};
      end
   end
   assign det = detect_t'(det_sync_reg);
   // press is the falling edge of the synced button; no debounce, the pin is assumed clean
   wire btn_press = btn_reg[2] & ~btn_reg[1];

   // ---------------- millisecond tick and blink phases ----------------
   logic [19:0] pre_reg;
   logic [9:0]  blink_ms_reg;
   wire         tick = (pre_reg == 20'(CYCLES_PER_MS - 1));

   // one shared tick keeps every blink in step, so video and auto LEDs blink together
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pre_reg      <= 20'h0;
         blink_ms_reg <= 10'h0;
      end else begin
         pre_reg      <= tick ? 20'h0 : pre_reg + 20'h1;
         if (tick) begin
            blink_ms_reg <= (blink_ms_reg == 10'(`FP_BLINK_MS - 1)) ? 10'h0 : blink_ms_reg + 10'h1;
         end
      end
   end
   wire slow_on  = (blink_ms_reg < 10'(`FP_SLOW_MS));
   wire fast_on  = blink_ms_reg[`FP_FAST_BIT];
   wire pause_on = (blink_ms_reg < 10'(`FP_PAUSE_MS));

   // ---------------- bus slave ----------------
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [31:0] ctrl_reg;
   logic [11:0] fwver_reg;
   logic [2:0]  vsel_reg;
   logic [2:0]  asel_reg;
   logic        auto_reg;

   wire addr_phase = i_hsel & i_htrans[1] & i_hready;
   wire rd_req     = addr_phase & ~i_hwrite;
   wire wr_ctrl    = wr_pend_reg & (wr_addr_reg == `FP_CTRL_OFS);
   wire wr_vsel    = wr_pend_reg & (wr_addr_reg == `FP_VSEL_OFS);
   wire wr_asel    = wr_pend_reg & (wr_addr_reg == `FP_ASEL_OFS);
   wire wr_fwver   = wr_pend_reg & (wr_addr_reg == `FP_FWVER_OFS);
   wire reboot     = wr_ctrl & i_hwdata[`FP_CTRL_REBOOT];

   assign o_hreadyout = 1'b1;   // zero wait state, always OKAY
   assign o_hresp     = 1'b0;

   // write address is held until the data phase, when hwdata is valid
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h0;
      end else begin
         wr_pend_reg <= addr_phase & i_hwrite;
         wr_addr_reg <= i_haddr[7:0];
      end
   end

   // software-owned settings; reboot is a self-clearing strobe
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg  <= `FP_CTRL_RST;
         fwver_reg <= `FP_FWVER_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= {30'h0, i_hwdata[`FP_CTRL_DVI], 1'b0};
         end
         if (wr_fwver) begin
            fwver_reg <= i_hwdata[11:0];
         end
      end
   end
   wire dvi_mode = ctrl_reg[`FP_CTRL_DVI];

   // ---------------- input selection ----------------
   boot_state_t state_reg;
   wire         running = (state_reg == ST_RUN);

   // first valid port, lowest code first; with no valid port the pick stays at vsel_reg
   logic [2:0] auto_pick;
   always_comb begin
      auto_pick = vsel_reg;
      for (int i = 4; i >= 0; i--) begin
         if (det.video_valid[i]) begin
            auto_pick = 3'(i);
         end
      end
   end
   wire any_video = |det.video_valid;

   // button walks VGA..DVI-A, then auto, then wraps; remote writes win over a press in the same cycle
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         vsel_reg <= `FP_VSEL_RST;
         asel_reg <= `FP_ASEL_RST;
         auto_reg <= 1'b0;
      end else begin
         if (wr_vsel) begin
            vsel_reg <= (i_hwdata[2:0] > VID_DVIA) ? vsel_reg : i_hwdata[2:0];
         end else if (wr_ctrl) begin
            auto_reg <= i_hwdata[`FP_CTRL_AUTO];
         end else if (btn_press && running) begin
            if (auto_reg) begin
               auto_reg <= 1'b0;
               vsel_reg <= VID_VGA;
            end else if (vsel_reg == VID_DVIA) begin
               auto_reg <= 1'b1;
            end else begin
               vsel_reg <= vsel_reg + 3'h1;
            end
         end else if (auto_reg && any_video) begin
            vsel_reg <= auto_pick;
         end
         if (wr_asel && i_hwdata[2:0] <= AUD_AN2) begin
            asel_reg <= i_hwdata[2:0];
         end
      end
   end

   // ---------------- audio embedding ----------------
   wire [2:0] vid_now  = vsel_reg;
   wire       analog   = (asel_reg >= AUD_AN1);
   wire       pair_ok  = analog | ((asel_reg + 3'h1) == vid_now);
   wire       aud_act  = det.audio_valid[asel_reg];
   wire       pass_4k  = analog & det.video_4k;
   wire       embed    = aud_act & pair_ok & ~pass_4k & ~dvi_mode;
   wire       search   = auto_reg & ~any_video;

   route_t route_next;
   always_comb begin
      route_next.video       = video_port_t'(vid_now);
      route_next.audio       = audio_port_t'(asel_reg);
      route_next.embed       = embed;
      route_next.passthrough = pass_4k;
   end

   // ---------------- normal-run LED pattern ----------------
   led_t run_led;
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         run_led.video[i] = search ? slow_on :
                            ((vid_now == 3'(i)) & det.video_valid[i]);
         if (asel_reg != 3'(i)) begin
            run_led.audio[i] = 1'b0;
         end else if (!aud_act) begin
            run_led.audio[i] = slow_on;
         end else if (pass_4k) begin
            run_led.audio[i] = fast_on;
         end else if (!embed) begin
            run_led.audio[i] = pause_on;
         end else begin
            run_led.audio[i] = 1'b1;
         end
      end
      run_led.hdcp     = det.hdcp_on;
      run_led.auto_sel = auto_reg & (search ? slow_on : 1'b1);
      unique case (det.link_mode)
         LINK_NONE:  run_led.twisted_pair_link_led = 1'b0;
         LINK_LOWPW: run_led.twisted_pair_link_led = slow_on;
         LINK_ETH:   run_led.twisted_pair_link_led = fast_on;
         LINK_FULL:  run_led.twisted_pair_link_led = 1'b1;
      endcase
   end

   // ---------------- start-up sequence ----------------
   logic [10:0] seq_ms_reg;
   logic [1:0]  dig_idx_reg;
   logic [3:0]  blinks_reg;

   wire [3:0]  digit    = (dig_idx_reg == 2'h0) ? fwver_reg[`FP_FW_D0_LSB +: 4] :
                          (dig_idx_reg == 2'h1) ? fwver_reg[`FP_FW_D1_LSB +: 4] :
                                                  fwver_reg[`FP_FW_D2_LSB +: 4];
   wire [3:0]  need     = (state_reg == ST_WP_BLINK) ? 4'h2 :
                          ((digit == 4'h0) ? 4'h1 : digit);   // a zero digit still takes one dark slot
   wire        slot_end = tick & (seq_ms_reg == 11'(`FP_DIGIT_ON_MS + `FP_DIGIT_OFF_MS - 1));
   wire        last_bl  = ((blinks_reg + 4'h1) == need);
   wire        blink_on = (seq_ms_reg < 11'(`FP_DIGIT_ON_MS));

   logic [10:0] hold_ms;
   always_comb begin
      unique case (state_reg)
         ST_ALL_ON:  hold_ms = 11'(`FP_ALL_ON_MS - 1);
         ST_GAP:     hold_ms = 11'(`FP_GAP_MS - 1);
         ST_ALL_OFF: hold_ms = 11'(`FP_ALL_OFF_MS - 1);
         default:    hold_ms = 11'(`FP_DIGIT_ON_MS + `FP_DIGIT_OFF_MS - 1);
      endcase
   end
   wire hold_end = tick & (seq_ms_reg == hold_ms);

   // reset and a software reboot both replay the sequence; a reboot keeps vsel_reg and asel_reg, but auto_reg takes bit 0 of its write
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_reg   <= WALL_PLATE ? ST_WP_BLINK : ST_ALL_ON;
         seq_ms_reg  <= 11'h0;
         dig_idx_reg <= 2'h0;
         blinks_reg  <= 4'h0;
      end else if (reboot) begin
         state_reg   <= WALL_PLATE ? ST_WP_BLINK : ST_ALL_ON;
         seq_ms_reg  <= 11'h0;
         dig_idx_reg <= 2'h0;
         blinks_reg  <= 4'h0;
      end else if (state_reg != ST_RUN) begin
         if (hold_end) begin
            seq_ms_reg <= 11'h0;
         end else if (tick) begin
            seq_ms_reg <= seq_ms_reg + 11'h1;
         end
         unique case (state_reg)
            ST_WP_BLINK: begin
               if (slot_end) begin
                  blinks_reg <= last_bl ? 4'h0 : blinks_reg + 4'h1;
                  if (last_bl) begin
                     state_reg <= ST_ALL_ON;
                  end
               end
            end
            ST_ALL_ON: begin
               if (hold_end) begin
                  state_reg <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (hold_end) begin
                  state_reg <= ST_DIGIT;
               end
            end
            ST_DIGIT: begin
               if (slot_end) begin
                  blinks_reg <= last_bl ? 4'h0 : blinks_reg + 4'h1;
                  if (last_bl) begin
                     dig_idx_reg <= dig_idx_reg + 2'h1;
                     if (dig_idx_reg == 2'h2) begin
                        state_reg <= ST_ALL_OFF;
                     end
                  end
               end
            end
            ST_ALL_OFF: begin
               if (hold_end) begin
                  state_reg <= ST_RUN;
               end
            end
            default: state_reg <= ST_RUN;
         endcase
      end
   end

   // ---------------- LED mux ----------------
   led_t led_next;
   always_comb begin
      led_next = '1;
      unique case (state_reg)
         ST_WP_BLINK: begin
            led_next          = '0;
            led_next.auto_sel = blink_on;
         end
         ST_ALL_ON:  led_next = '1;
         ST_GAP:     led_next.video[2:0] = 3'h0;
         ST_DIGIT: begin
            for (int i = 0; i < 3; i++) begin
               led_next.video[i] = (dig_idx_reg == 2'(i)) & blink_on & (digit != 4'h0);
            end
         end
         ST_ALL_OFF: led_next = '0;
         ST_RUN:     led_next = run_led;
      endcase
   end

   // ---------------- status read-back ----------------
   logic [31:0] status;
   always_comb begin
      status                    = 32'h0;
      status[`FP_ST_VID_LSB +: 3] = vid_now;
      status[`FP_ST_AUD_LSB +: 3] = asel_reg;
      status[`FP_ST_EMBED]      = embed;
      status[`FP_ST_PASS]       = pass_4k;
      status[`FP_ST_BUSY]       = ~running;
      status[`FP_ST_SEARCH]     = search;
   end

   wire [7:0]  rd_ofs = i_haddr[7:0];
   wire [31:0] rd_val = (rd_ofs == `FP_CTRL_OFS)   ? {30'h0, dvi_mode, auto_reg} :
                        (rd_ofs == `FP_VSEL_OFS)   ? {29'h0, vsel_reg} :
                        (rd_ofs == `FP_ASEL_OFS)   ? {29'h0, asel_reg} :
                        (rd_ofs == `FP_FWVER_OFS)  ? {20'h0, fwver_reg} :
                        (rd_ofs == `FP_STATUS_OFS) ? status : 32'h0;

   // data, LED and route outputs come from flops; read data is caught in the address phase
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_hrdata <= 32'h0;
         o_led    <= '0;
         o_route  <= '0;
      end else begin
         if (rd_req) begin
            o_hrdata <= rd_val;
         end
         o_led   <= led_next;
         o_route <= route_next;
      end
   end

endmodule
